// ==== src/acc_channel.sv ====
// converter channel control: axi4-lite registers, trigger, routing, compare flag, irq
//
// Contract
// RQ1 - trigger bit starts conversion, cleared when started
// RQ2 - pending trigger rewrite queues nothing more
// RQ3 - trigger aliases module control start bit
// RQ4 - unused bits read as zero
// RQ5 - gain field codes give 1x..64x, half
// RQ6 - gain applies only through gain stage
// RQ7 - unsigned mode: internal, one-sided, rest reserved
// RQ8 - signed mode adds both differential kinds
// RQ9 - internal select: temperature, bandgap, scaled supply
// RQ10 - pin kinds route pin n positive
// RQ11 - pin count parameter, higher codes undefined
// RQ12 - negative select only for differential kinds
// RQ13 - plain differential negative: pins 0-3, grounds
// RQ14 - gained differential negative: pins 4-7, grounds
// RQ15 - condition field: complete, below, above
// RQ16 - priority field enables and levels interrupt
// RQ17 - irq when flag set and level nonzero
// RQ18 - flag set by event, cleared by vector/write
// RQ19 - compare against threshold, signed when signed mode
// RQ20 - routed positive is select plus scan offset
// RQ21 - compare evaluated once per completed conversion
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module acc_channel
    import acc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // conversion core
    output logic conv_start,
    input wire logic conv_started,
    input wire logic conv_done,
    input wire logic [15:0] conv_result,
    // analog multiplexers and gain stage
    output logic [4:0] mux_pos,
    output logic [4:0] mux_neg,
    output logic [2:0] gain_code,
    // interrupt controller
    output logic [1:0] irq_level,
    input wire logic irq_vector_ack
);

    // ==========================================================
    // registers
    logic trig_q;               // pending conversion trigger
    logic [4:0] ctrl_q;         // gain[4:2] and input kind[1:0]
    logic [6:0] insel_q;        // positive[6:3] and negative[2:0]
    logic [3:0] intc_q;         // condition[3:2] and priority[1:0]
    logic flag_q;               // channel flag
    logic [15:0] cmp_q;         // compare_threshold
    logic signed_q;             // signed_conversion_select
    logic [3:0] scan_off_q, scan_cnt_q;    // scan offset, count nonzero enables scanning
    acc_state_e state_q, state_d;    // sequencing state
    // bus holding registers and registered outputs
    logic aw_full_q, aw_bad_q, w_full_q;
    logic [3:0] aw_idx_q, wstrb_q;
    logic [31:0] wdata_q, rdata_q;
    logic bvalid_q, rvalid_q, conv_start_q;
    logic [1:0] bresp_q, rresp_q, irq_q;
    logic [4:0] mux_pos_q, mux_neg_q;
    logic [2:0] gain_q;

    // ==========================================================
    // address decode function: word index, with a mapped flag
    function automatic logic [4:0] acc_decode(input logic [31:0] addr);
        logic ok;
        ok = (addr[31:5] == 27'h0) && (addr[1:0] == 2'h0);
        return {ok, 1'b0, addr[4:2]} | 5'h00;
    endfunction
    // write path decode
    logic wr_fire, wr_ok;    // both address and data held, response slot free
    logic [7:0] wbyte;    // low byte of write data
    logic wr_ctrl, wr_insel, wr_intc, wr_flag;
    logic wr_cmp_lo, wr_cmp_hi, wr_mod, wr_scan;
    logic [4:0] aw_dec, ar_dec;
    assign aw_dec = acc_decode(s_axi_awaddr);
    assign ar_dec = acc_decode(s_axi_araddr);
    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
    assign wr_ok = wr_fire && !aw_bad_q && wstrb_q[0];
    assign wbyte = wdata_q[7:0];
    assign wr_ctrl = wr_ok && (aw_idx_q == ACC_IDX_CTRL);
    assign wr_insel = wr_ok && (aw_idx_q == ACC_IDX_INSEL);
    assign wr_intc = wr_ok && (aw_idx_q == ACC_IDX_INTC);
    assign wr_flag = wr_ok && (aw_idx_q == ACC_IDX_FLAG);
    assign wr_cmp_lo = wr_ok && (aw_idx_q == ACC_IDX_CMP);
    assign wr_cmp_hi = wr_fire && !aw_bad_q && wstrb_q[1] && (aw_idx_q == ACC_IDX_CMP);
    assign wr_mod = wr_ok && (aw_idx_q == ACC_IDX_MOD);
    assign wr_scan = wr_ok && (aw_idx_q == ACC_IDX_SCAN);
    // trigger writes through either location reach one bit
    logic trig_write;
    assign trig_write = (wr_ctrl && wbyte[ACC_TRIG_BIT])
        || (wr_mod && wbyte[ACC_MOD_TRIG_BIT]);    // [RQ3]
    // ==========================================================
    // routing decode
    logic [4:0] pos_route, neg_route;
    logic [2:0] gain_dec;
    acc_route u_route (
        .kind(ctrl_q[1:0]),
        .pos_sel(insel_q[6:3]),
        .neg_sel(insel_q[2:0]),
        .gain_sel(ctrl_q[4:2]),
        .signed_mode(signed_q),
        .scan_offset(scan_cnt_q != 4'h0 ? scan_off_q : 4'h0),
        .pos_route(pos_route),
        .neg_route(neg_route),
        .gain_code(gain_dec),
        .gain_used()
    );

    // ==========================================================
    // compare and flag event
    logic below, above, event_hit;
    assign below = signed_q ? ($signed(conv_result) < $signed(cmp_q))
        : (conv_result < cmp_q);    // [RQ19]
    assign above = signed_q ? ($signed(conv_result) > $signed(cmp_q))
        : (conv_result > cmp_q);    // [RQ19]
    // condition chosen once per completed conversion
    assign event_hit = conv_done && (state_q == ACC_BUSY) && (
        (intc_q[3:2] == ACC_COND_COMPLETE)
        || (intc_q[3:2] == ACC_COND_BELOW && below)
        || (intc_q[3:2] == ACC_COND_ABOVE && above));    // [RQ15] [RQ21]

    // ==========================================================
    // sequencing: idle until trigger, start until core accepts, busy until done
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ACC_IDLE: if (trig_q) state_d = ACC_START;              // [RQ1]
            ACC_START: if (conv_started) state_d = ACC_BUSY;        // [RQ1]
            ACC_BUSY: if (conv_done) state_d = ACC_IDLE;
            default: state_d = ACC_IDLE;
        endcase
    end
    // state and trigger bit
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= ACC_IDLE;
            trig_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            // clear once started, a write while pending only keeps it set
            if (state_q == ACC_START && conv_started)
                trig_q <= 1'b0;                  // [RQ1]
            else if (trig_write)
                trig_q <= 1'b1;                  // [RQ2]
        end
    end
    // configuration registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= ACC_RST_BYTE[4:0];
            insel_q <= ACC_RST_BYTE[6:0];
            intc_q <= ACC_RST_BYTE[3:0];
            cmp_q <= ACC_RST_CMP;
            signed_q <= 1'b0;
            scan_cnt_q <= 4'h0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= wbyte[4:0];
            if (wr_insel)
                insel_q <= wbyte[6:0];
            if (wr_intc)
                intc_q <= wbyte[3:0];
            if (wr_cmp_lo)
                cmp_q[7:0] <= wbyte;
            if (wr_cmp_hi)
                cmp_q[15:8] <= wdata_q[15:8];
            if (wr_mod)
                signed_q <= wbyte[ACC_MOD_SIGNED_BIT];
            if (wr_scan)
                scan_cnt_q <= wbyte[3:0];
        end
    end
    // scan offset: steps per conversion, wraps after reaching count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            scan_off_q <= 4'h0;
        else if (wr_scan)
            scan_off_q <= wbyte[7:4];
        else if (conv_done && state_q == ACC_BUSY && scan_cnt_q != 4'h0)
            scan_off_q <= (scan_off_q == scan_cnt_q) ? 4'h0 : scan_off_q + 4'h1;    // [RQ20]
    end
    // channel flag: set wins over clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flag_q <= 1'b0;
        else if (event_hit)
            flag_q <= 1'b1;                                   // [RQ18]
        else if (irq_vector_ack || (wr_flag && wbyte[0]))
            flag_q <= 1'b0;                                   // [RQ18]
    end
    // outputs to core, multiplexers and interrupt controller
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            conv_start_q <= 1'b0;
            mux_pos_q <= ACC_ROUTE_NONE;
            mux_neg_q <= ACC_ROUTE_NONE;
            gain_q <= ACC_GAIN_UNITY;
            irq_q <= 2'h0;
        end
        else
        begin
            conv_start_q <= (state_d == ACC_START);
            mux_pos_q <= pos_route;
            mux_neg_q <= neg_route;
            gain_q <= gain_dec;
            irq_q <= flag_q ? intc_q[1:0] : 2'h0;    // [RQ16] [RQ17]
        end
    end

    // ==========================================================
    // axi write channel capture and response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            aw_idx_q <= 4'h0;
            aw_bad_q <= 1'b0;
            w_full_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= ACC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_full_q)
            begin
                aw_full_q <= 1'b1;
                aw_idx_q <= {1'b0, aw_dec[2:0]};
                aw_bad_q <= !aw_dec[4];
            end
            if (s_axi_wvalid && !w_full_q)
            begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= aw_bad_q ? ACC_RESP_SLVERR : ACC_RESP_OKAY;
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // read data mux, unused bits zero
    logic [31:0] rd_word;
    assign rd_word = (ar_dec[2:0] == ACC_IDX_CTRL[2:0]) ? {24'h0, trig_q, 2'b00, ctrl_q}
        : (ar_dec[2:0] == ACC_IDX_INSEL[2:0]) ? {24'h0, 1'b0, insel_q}      // [RQ4]
        : (ar_dec[2:0] == ACC_IDX_INTC[2:0]) ? {24'h0, 4'h0, intc_q}        // [RQ4]
        : (ar_dec[2:0] == ACC_IDX_FLAG[2:0]) ? {31'h0, flag_q}
        : (ar_dec[2:0] == ACC_IDX_CMP[2:0]) ? {16'h0, cmp_q}
        : (ar_dec[2:0] == ACC_IDX_MOD[2:0]) ? {27'h0, signed_q, 1'b0, trig_q, 2'b00}
        : (ar_dec[2:0] == ACC_IDX_SCAN[2:0]) ? {24'h0, scan_off_q, scan_cnt_q}
        : {30'h0, state_q};

    // axi read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= ACC_RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= ar_dec[4] ? rd_word : 32'h0000_0000;
            rresp_q <= ar_dec[4] ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // ==========================================================
    // output wiring
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign conv_start = conv_start_q;
    assign mux_pos = mux_pos_q;
    assign mux_neg = mux_neg_q;
    assign gain_code = gain_q;
    assign irq_level = irq_q;

    // ==========================================================
    // assertions
    sequence trig_taken_s;
        state_q == ACC_START && conv_started;
    endsequence
    trig_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)    // [RQ1]
        trig_taken_s |=> !trig_q) else $error("trigger not cleared after start");
    trig_start_a: assert property (@(posedge aclk) disable iff (!aresetn)    // [RQ1]
        (state_q == ACC_IDLE && trig_q) |=> ##1 conv_start) else $error("no start request");
    no_requeue_a: assert property (@(posedge aclk) disable iff (!aresetn)    // [RQ2]
        (trig_q && trig_write && !(state_q == ACC_START && conv_started)) |=> trig_q)
        else $error("pending trigger disturbed");
    alias_read_a: assert property (@(posedge aclk) disable iff (!aresetn)    // [RQ3]
        (s_axi_arvalid && !rvalid_q && ar_dec[4] && ar_dec[2:0] == ACC_IDX_MOD[2:0])
        |=> rdata_q[ACC_MOD_TRIG_BIT] == $past(trig_q)) else $error("alias read mismatch");
    zero_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)    // [RQ4]
        rvalid_q |-> rdata_q[31:8] == 24'h0) else $error("upper bits not zero");
    gain_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)    // [RQ6]
        ctrl_q[1:0] != ACC_KIND_DIFFERENTIAL_PLAIN_GAINED |=> gain_code == ACC_GAIN_UNITY)
        else $error("gain applied off gain route");
    neg_unused_a: assert property (@(posedge aclk) disable iff (!aresetn)    // [RQ12]
        !ctrl_q[1] |=> mux_neg == ACC_ROUTE_NONE) else $error("negative used when single");
    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)    // [RQ17]
        flag_q |=> irq_level == $past(intc_q[1:0])) else $error("irq level wrong");
    flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)    // [RQ18]
        event_hit |=> flag_q) else $error("flag not set on event");
    below_hit_a: assert property (@(posedge aclk) disable iff (!aresetn)    // [RQ15]
        (conv_done && state_q == ACC_BUSY && intc_q[3:2] == ACC_COND_BELOW && below)
        |=> flag_q) else $error("below condition missed");

endmodule
`default_nettype wire

// ==== src/acc_pkg.sv ====
// package: register map, field layout, codes and sequencing states for the converter channel control
package acc_pkg;

    // ==========================================================
    // register offsets (printed offsets are not word multiples: index, byte = 4 * index)
    localparam logic [3:0] ACC_IDX_CTRL = 4'h0;    // channel_control
    localparam logic [3:0] ACC_IDX_INSEL = 4'h1;   // channel_input_select
    localparam logic [3:0] ACC_IDX_INTC = 4'h2;    // channel_interrupt_control
    localparam logic [3:0] ACC_IDX_FLAG = 4'h3;    // channel flag (write one clears)
    localparam logic [3:0] ACC_IDX_CMP = 4'h4;     // compare_threshold, 16 bits
    localparam logic [3:0] ACC_IDX_MOD = 4'h5;     // module_control_first alias and mode
    localparam logic [3:0] ACC_IDX_SCAN = 4'h6;    // scan offset and count
    localparam logic [3:0] ACC_IDX_STAT = 4'h7;    // state readback

    // ==========================================================
    // field positions
    localparam int ACC_TRIG_BIT = 7;          // conversion trigger in channel_control
    localparam int ACC_MOD_TRIG_BIT = 2;      // module_channel_trigger in module control
    localparam int ACC_MOD_SIGNED_BIT = 4;    // signed_conversion_select in module control

    // ==========================================================
    // reset values and widths
    localparam logic [7:0] ACC_RST_BYTE = 8'h00;
    localparam logic [15:0] ACC_RST_CMP = 16'h0000;
    localparam int ACC_NUM_PINS = 16;          // analog input pins implemented

    // ==========================================================
    // input kinds
    localparam logic [1:0] ACC_KIND_INTERNAL = 2'h0;
    localparam logic [1:0] ACC_KIND_ONE_SIDED = 2'h1;
    localparam logic [1:0] ACC_KIND_DIFFERENTIAL_PLAIN_PLAIN = 2'h2;
    localparam logic [1:0] ACC_KIND_DIFFERENTIAL_PLAIN_GAINED = 2'h3;

    // irq conditions
    localparam logic [1:0] ACC_COND_COMPLETE = 2'h0;
    localparam logic [1:0] ACC_COND_BELOW = 2'h1;
    localparam logic [1:0] ACC_COND_ABOVE = 2'h3;

    // analog route codes driven to the multiplexers
    localparam logic [4:0] ACC_ROUTE_NONE = 5'h1F;       // no defined source
    localparam logic [4:0] ACC_ROUTE_TEMP = 5'h10;       // temperature reference
    localparam logic [4:0] ACC_ROUTE_BANDGAP = 5'h11;    // bandgap
    localparam logic [4:0] ACC_ROUTE_SCALED = 5'h12;     // scaled_supply_input
    localparam logic [4:0] ACC_ROUTE_PAD_GND = 5'h13;    // pad ground
    localparam logic [4:0] ACC_ROUTE_INT_GND = 5'h14;    // internal_ground_ref
    localparam logic [2:0] ACC_GAIN_HALF = 3'h7;         // gain code for one half
    localparam logic [2:0] ACC_GAIN_UNITY = 3'h0;        // gain code for 1x

    // axi responses
    localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

    // ==========================================================
    // channel sequencing states
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_START = 2'b01,
        ACC_BUSY = 2'b10
    } acc_state_e;

endpackage

// ==== src/acc_route.sv ====
// route decoder: input kind and selects into analog multiplexer and gain codes
`timescale 1ns/10ps
`default_nettype none

module acc_route
    import acc_pkg::*;
(
    // configuration
    input wire logic [1:0] kind,
    input wire logic [3:0] pos_sel,
    input wire logic [2:0] neg_sel,
    input wire logic [2:0] gain_sel,
    input wire logic signed_mode,
    input wire logic [3:0] scan_offset,
    // decoded routing
    output logic [4:0] pos_route,
    output logic [4:0] neg_route,
    output logic [2:0] gain_code,
    output logic gain_used
);

    // ==========================================================
    // positive select with scan offset
    logic [3:0] pos_eff;    // select plus offset, wraps at four bits
    logic kind_differential_plain;        // differential kinds need signed mode
    logic kind_valid;       // kind allowed in current conversion mode

    assign pos_eff = pos_sel + scan_offset;    // [RQ20]
    assign kind_differential_plain = kind[1];
    assign kind_valid = !kind_differential_plain || signed_mode;    // [RQ7] [RQ8]

    // positive route
    always_comb
    begin
        pos_route = ACC_ROUTE_NONE;
        if (!kind_valid)
        begin
            pos_route = ACC_ROUTE_NONE;    // [RQ7] reserved in unsigned mode
        end
        else if (kind == ACC_KIND_INTERNAL)
        begin
            // [RQ9] internal sources, other codes reserved
            case (pos_eff)
                4'h0: pos_route = ACC_ROUTE_TEMP;
                4'h1: pos_route = ACC_ROUTE_BANDGAP;
                4'h2: pos_route = ACC_ROUTE_SCALED;
                default: pos_route = ACC_ROUTE_NONE;
            endcase
        end
        else if (32'(pos_eff) < ACC_NUM_PINS)
        begin
            pos_route = {1'b0, pos_eff};    // [RQ10] [RQ11]
        end
    end

    // negative route, differential kinds only
    always_comb
    begin
        neg_route = ACC_ROUTE_NONE;    // [RQ12] unused otherwise
        if (kind_valid && kind == ACC_KIND_DIFFERENTIAL_PLAIN_PLAIN)
        begin
            // [RQ13]
            case (neg_sel)
                3'h0, 3'h1, 3'h2, 3'h3: neg_route = {2'b00, neg_sel};
                3'h5: neg_route = ACC_ROUTE_PAD_GND;
                3'h7: neg_route = ACC_ROUTE_INT_GND;
                default: neg_route = ACC_ROUTE_NONE;
            endcase
        end
        else if (kind_valid && kind == ACC_KIND_DIFFERENTIAL_PLAIN_GAINED)
        begin
            // [RQ14]
            case (neg_sel)
                3'h0, 3'h1, 3'h2, 3'h3: neg_route = {2'b00, 1'b1, neg_sel[1:0]};
                3'h4: neg_route = ACC_ROUTE_INT_GND;
                3'h7: neg_route = ACC_ROUTE_PAD_GND;
                default: neg_route = ACC_ROUTE_NONE;
            endcase
        end
    end

    // gain only through the gain stage route
    assign gain_used = kind_valid && (kind == ACC_KIND_DIFFERENTIAL_PLAIN_GAINED);    // [RQ6]
    assign gain_code = gain_used ? gain_sel : ACC_GAIN_UNITY;          // [RQ5]

endmodule
`default_nettype wire

// ==== test/acc_core_model.sv ====
// conversion core model: answers a start request with started and done pulses
`timescale 1ns/10ps
`default_nettype none
module acc_core_model (
    // clock, reset and pacing
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    // request and result source
    input wire logic conv_start,
    input wire logic [15:0] result_in,
    // answers
    output logic conv_started,
    output logic conv_done,
    output logic [15:0] conv_result
);
    logic [1:0] ph_q; // 0 idle, 1 starting, 2 converting
    logic [3:0] cnt_q; // wait before the next pulse
    // ====
    // wait, pulse started, wait, pulse done with the result
    always_ff @(posedge aclk)
    begin
        conv_started <= 1'b0;
        conv_done <= 1'b0;
        conv_result <= ~result_in; // no stale value outside done
        if (!aresetn)
            ph_q <= 2'h0;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
        else if (ph_q == 2'h0 && conv_start)
        begin
            ph_q <= 2'h1;
            cnt_q <= slow ? 4'hC : 4'h0;
        end
        else if (ph_q == 2'h1)
        begin
            conv_started <= 1'b1;
            ph_q <= 2'h2;
            cnt_q <= slow ? 4'h6 : 4'h1;
        end
        else if (ph_q == 2'h2)
        begin
            conv_done <= 1'b1;
            conv_result <= result_in;
            ph_q <= 2'h0;
        end
        if (!aresetn)
            cnt_q <= 4'h0;
    end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// testbench: register map, routing table, trigger, flag and interrupt checks
`timescale 1ns/10ps
`default_nettype none
module tb;
    import acc_pkg::*;
    logic aclk = 0, aresetn = 0, slow = 1, ack = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rd_q;
    logic [3:0] wstrb = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, cstart, cstarted, cdone;
    logic [1:0] bresp, rresp, irq, rs;
    logic [4:0] mpos, mneg;
    logic [2:0] gain;
    logic [15:0] cres, res_in = 0;
    int n_fail = 0, cmp_count = 0, n_start = 0;
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) if (cstarted === 1'b1) n_start++;
    acc_channel dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .conv_start(cstart), .conv_started(cstarted),
        .conv_done(cdone), .conv_result(cres), .mux_pos(mpos), .mux_neg(mneg),
        .gain_code(gain), .irq_level(irq), .irq_vector_ack(ack));
    acc_core_model core (.aclk(aclk), .aresetn(aresetn), .slow(slow), .conv_start(cstart),
        .result_in(res_in), .conv_started(cstarted), .conv_done(cdone), .conv_result(cres));
    // ====
    // compare, bus and closing tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask
    function automatic logic [31:0] ad(input logic [3:0] i);
        return {26'h0, i, 2'b00};
    endfunction
    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        int k;
        awaddr <= ad(i);
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 40 && !(bvalid && bready); k++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        rs = bresp;
        bready <= 1'b0;
        if (k == 40) n_fail++;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [31:0] a);
        int k;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 40 && !(rvalid && rready); k++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        rd_q = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (k == 40) n_fail++;
        @(posedge aclk);
    endtask
    task automatic run(input logic [15:0] r);
        int k;
        res_in <= r;
        wr(ACC_IDX_MOD, 32'h14);
        for (k = 0; k < 60 && cdone !== 1'b1; k++) @(posedge aclk);
        repeat (3) @(posedge aclk);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ====
    // scenarios
    task automatic t_regs;
        for (int i = 0; i < 3; i++)
        begin
            rd(ad(i[3:0]));
            chk(rd_q, 32'h0);
        end
        rd(32'h40);
        chk(rs, ACC_RESP_SLVERR);
        wr(ACC_IDX_CTRL, 32'h7F);
        wr(ACC_IDX_INSEL, 32'hFF);
        wr(ACC_IDX_INTC, 32'hF0);
        wr(4'h8, 32'h0);
        chk(rs, ACC_RESP_SLVERR);
        chk(mpos, ACC_ROUTE_NONE);
        rd(ad(ACC_IDX_CTRL));
        chk(rd_q, 32'h1F);
        rd(ad(ACC_IDX_INSEL));
        chk(rd_q, 32'h7F);
        rd(ad(ACC_IDX_INTC));
        chk(rd_q, 32'h0);
        $display("done t_regs");
    endtask
    task automatic t_route;
        logic [7:0] c[5] = '{8'h1F, 8'h0A, 8'h00, 8'h01, 8'h13};
        logic [7:0] s[5] = '{8'h7F, 8'h7F, 8'h17, 8'h2B, 8'h01};
        logic [4:0] p[5] = '{5'h0F, 5'h0F, 5'h12, 5'h05, 5'h00};
        logic [4:0] n[5] = '{5'h13, 5'h14, 5'h1F, 5'h1F, 5'h05};
        logic [2:0] g[5] = '{3'h7, 3'h0, 3'h0, 3'h0, 3'h4};
        wr(ACC_IDX_MOD, 32'h10);
        for (int i = 0; i < 5; i++)
        begin
            wr(ACC_IDX_CTRL, c[i]);
            wr(ACC_IDX_INSEL, s[i]);
            chk(mpos, p[i]);
            chk(mneg, n[i]);
            chk(gain, g[i]);
        end
        wr(ACC_IDX_SCAN, 32'h21);
        chk(mpos, 5'h02);
        wr(ACC_IDX_SCAN, 32'h0);
        $display("done t_route");
    endtask
    task automatic t_conv;
        wr(ACC_IDX_INTC, 32'h02);
        wr(ACC_IDX_CTRL, 32'h93);
        rd(ad(ACC_IDX_CTRL));
        chk(rd_q[7], 1'b1);
        rd(ad(ACC_IDX_MOD));
        chk(rd_q[2], 1'b1);
        wr(ACC_IDX_CTRL, 32'h93);
        for (int k = 0; k < 60 && cdone !== 1'b1; k++) @(posedge aclk);
        repeat (3) @(posedge aclk);
        chk(n_start, 1);
        rd(ad(ACC_IDX_CTRL));
        chk(rd_q, 32'h13);
        rd(ad(ACC_IDX_FLAG));
        chk(rd_q, 32'h1);
        chk(irq, 2'h2);
        wr(ACC_IDX_FLAG, 32'h1);
        chk(irq, 2'h0);
        $display("done t_conv");
    endtask
    task automatic t_cmp;
        slow <= 1'b0;
        wr(ACC_IDX_CMP, 32'h0100);
        wr(ACC_IDX_INTC, 32'h06);
        run(16'h0200);
        chk(irq, 2'h0);
        run(16'hFF00);
        chk(irq, 2'h2);
        ack <= 1'b1;
        @(posedge aclk);
        ack <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(irq, 2'h0);
        wr(ACC_IDX_INTC, 32'h0D);
        run(16'h0200);
        chk(irq, 2'h1);
        $display("done t_cmp");
    endtask
    // ====
    // main sequence and watchdog
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        t_route;
        t_conv;
        t_cmp;
        finish_test;
    end
    initial
    begin
        #200us;
        n_fail++;
        finish_test;
    end
endmodule
`default_nettype wire
